// ===== logic/ics_pkg.sv
// shared constants and types for the instruction sampling counters
package ics_pkg;
  localparam int CW = 20;
  localparam int PCW = 64;
  localparam int SLOTS = 4;
  localparam int OVR_W = 3;
  localparam int MISS_LEAD = 3;
  localparam logic [CW-1:0] CTR_WRITE_BIAS = 20'h00004;
  localparam logic [OVR_W-1:0] OVR_MAX = 3'h7;
  localparam logic [2:0] OPEN_DELAY = 3'h5;
  localparam logic [2:0] OVR_LAST = 3'h2;
  localparam logic [1:0] CLOSE_DELAY = 2'h2;
  localparam logic [1:0] HOLD_SKIP = 2'h2;
  // control register field positions
  localparam int SL1_LO = 2;
  localparam int SL0_BIT = 4;
  localparam int CTR1_LO = 6;
  localparam int RET_OK_BIT = 26;
  localparam int BR_DIR_BIT = 27;
  localparam int STALL_BIT = 28;
  localparam int KILL_BIT = 29;
  localparam int CTR0_LO = 44;
  // status register field positions
  localparam int FILL_BIT = 0;
  localparam int TRAP_BIT = 1;
  localparam int WRONG_BIT = 2;
  localparam int KIND_LO = 3;
  localparam int KIND_W = 4;
  localparam int LSO_BIT = 7;
  localparam int OVR_LO = 8;
  // input select pair codes
  localparam logic [1:0] SEL_RET_CYC = 2'h0;
  localparam logic [1:0] SEL_CYC_HOLD = 2'h1;
  localparam logic [1:0] SEL_RET_MISS = 2'h2;
  localparam logic [1:0] SEL_CYC_REPLAY = 2'h3;

  typedef enum logic [1:0] {
    ICS_SEL_PC,
    ICS_SEL_STAT,
    ICS_SEL_CTRL,
    ICS_SEL_NONE
  } ics_ipr_e;

  typedef enum {ICS_IDLE, ICS_DELAY, ICS_OPEN, ICS_CLOSE, ICS_DONE}
    ics_state_e;

  typedef struct packed {
    logic counter_zero_enable;
    logic counter_one_enable;
    logic system_wide_count_enable;
    logic process_count_enable;
  } ics_en_s;

  typedef struct packed {
    logic retire;
    logic trap;
    logic abort;
    logic squash_end;
    logic retire_hold;
  } ics_ev_s;

  typedef struct packed {
    logic new_fill_stream_flag;
    logic non_shadowed_trap_flag;
    logic wrong_branch_guess_flag;
    logic [KIND_W-1:0] trap_kind;
    logic load_store_order_replay;
    logic retired_ok_flag;
    logic branch_direction;
    logic fetch_map_stall;
    logic killed_by_map_stage;
  } ics_status_s;
endpackage

// ===== logic/ics_counters.sv
// instruction sampling performance counters with control/status registers
// Behaviour
// - squashed no-ops count as fetched instructions
// - conditional move arrives as two counted fetches
// - sample_mode_select one selects sampling mode
// - counter zero written value gets four added
// - count up to four fetches when enabled
// - overflowing fetch sampled, window at fifth cycle
// - fetches in two post-overflow cycles give overcount
// - trap or abort closes window two cycles later
// - retirement closes window two cycles later
// - squash closes window about two cycles later
// - after close counter zero halts until write
// - pending bits request the counter interrupt routine
// - capture sampled pc and status flags
// - control reports retire, direction, stall, kill
// - retire delay counted, at most window minus two
// - tags retire in order, delay between tags
// - retired count may drift four near edges
// - miss stream counted three cycles early
// - replay traps counted over window delayed one
// - input_select_pair chooses both counter inputs
// - overflow sets pending only when enabled
`timescale 1ns/10ps
module ics_counters (
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  input wire logic IPR_WR_I,
  input wire ics_pkg::ics_ipr_e IPR_SEL_I,
  input wire logic [ics_pkg::PCW-1:0] IPR_WDATA_I,
  output logic [ics_pkg::PCW-1:0] IPR_RDATA_O,
  input wire ics_pkg::ics_en_s EN_I,
  input wire logic [1:0] IRQ_ENABLE_I,
  input wire logic [ics_pkg::SLOTS-1:0] FETCH_VALID_I,
  input wire logic [ics_pkg::SLOTS-1:0][ics_pkg::PCW-1:0] FETCH_PC_I,
  input wire logic [3:0] RETIRE_CNT_I,
  input wire logic CACHE_MISS_I,
  input wire logic REPLAY_TRAP_I,
  input wire ics_pkg::ics_ev_s SMP_EV_I,
  input wire ics_pkg::ics_status_s SMP_STATUS_I,
  output logic SMP_PICK_O,
  output logic [1:0] SMP_SLOT_O,
  output logic WINDOW_O,
  output logic [1:0] IRQ_PENDING_O
);
  import ics_pkg::*;

  // counter one increment for the selected input
  function automatic logic inc_one(input logic [1:0] sel,
                                   input logic smp, input logic miss,
                                   input logic replay, input logic hold);
    logic r;
    r = 1'b0;
    case (sel)
      SEL_RET_CYC: r = 1'b1;
      SEL_CYC_HOLD: r = smp & hold;
      SEL_RET_MISS: r = miss;
      SEL_CYC_REPLAY: r = replay;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // counter zero takes retired instructions or cycles
  function automatic logic [3:0] inc_zero(input logic [1:0] sel,
                                          input logic [3:0] ret);
    return (sel == SEL_RET_CYC || sel == SEL_RET_MISS) ? ret : 4'h1;
  endfunction

  ics_state_e state, next_state;
  logic [CW-1:0] ctr0, next_ctr0, ctr1, next_ctr1;
  logic sl0, next_sl0;
  logic [1:0] sl1, next_sl1;
  logic [2:0] dly, next_dly;
  logic [1:0] ccnt, next_ccnt, age, next_age;
  logic [OVR_W-1:0] fetch_overcount, next_ovr;
  logic [PCW-1:0] spc, next_spc;
  ics_status_s stat, next_stat;
  logic [1:0] pend, next_pend;
  logic win_d1, next_win_d1;
  logic [MISS_LEAD-1:0] miss_sh, next_miss_sh;

  logic wr_ctrl, ok0, ok1, win, end_ev, ovf_hit;
  logic [1:0] hit_slot;
  logic [2:0] nfetch;
  logic [CW:0] acc;
  logic [CW:0] sum0, sum1;
  logic [PCW-1:0] pick_pc;

  assign wr_ctrl = IPR_WR_I && IPR_SEL_I == ICS_SEL_CTRL;
  assign ok0 = EN_I.counter_zero_enable &&
               (EN_I.system_wide_count_enable || EN_I.process_count_enable);
  assign ok1 = EN_I.counter_one_enable &&
               (EN_I.system_wide_count_enable || EN_I.process_count_enable);
  assign win = state == ICS_OPEN || state == ICS_CLOSE;
  assign end_ev = SMP_EV_I.retire || SMP_EV_I.trap || SMP_EV_I.abort ||
                  SMP_EV_I.squash_end;

  // walk the fetch slots in order; the slot whose carry first leaves the
  // counter is the sampled one, squashed no-ops and both move halves
  // arrive as ordinary valid slots
  always_comb begin
    acc = {1'b0, ctr0};
    ovf_hit = 1'b0;
    hit_slot = 2'h0;
    pick_pc = '0;
    nfetch = 3'h0;
    for (int i = 0; i < SLOTS; i++) begin
      if (FETCH_VALID_I[i]) begin
        nfetch = nfetch + 3'h1;
        acc = acc + 21'h000001;
        if (acc[CW] && !ovf_hit) begin
          ovf_hit = 1'b1;
          hit_slot = 2'(i);
          pick_pc = FETCH_PC_I[i];
        end
      end
    end
    ovf_hit = ovf_hit && sl0 && ok0 && state == ICS_IDLE;
  end

  always_comb begin
    next_state = state;
    next_ctr0 = ctr0;
    next_ctr1 = ctr1;
    next_sl0 = sl0;
    next_sl1 = sl1;
    next_dly = dly;
    next_ccnt = ccnt;
    next_age = age;
    next_ovr = fetch_overcount;
    next_spc = spc;
    next_stat = stat;
    next_pend = pend;
    next_win_d1 = win;
    // miss events are delayed so the window sees them three cycles late,
    // which is the same as counting the raw stream three cycles early
    next_miss_sh = {miss_sh[MISS_LEAD-2:0], CACHE_MISS_I};
    sum0 = '0;
    sum1 = '0;
    if (!sl0) begin
      // aggregate counting, kept simple: count on, wrap on overflow
      if (ok0) begin
        sum0 = {1'b0, ctr0} + {17'h00000, inc_zero(sl1, RETIRE_CNT_I)};
        next_ctr0 = sum0[CW-1:0];
      end
      if (ok1) begin
        sum1 = {1'b0, ctr1} + 21'(inc_one(sl1, 1'b0, CACHE_MISS_I,
                                          REPLAY_TRAP_I, 1'b0));
        next_ctr1 = sum1[CW-1:0];
      end
    end else begin
      case (state)
        ICS_IDLE: begin
          if (ok0) begin
            sum0 = {1'b0, ctr0} + {18'h00000, nfetch};
            next_ctr0 = sum0[CW-1:0];
          end
          if (ovf_hit) begin
            next_state = ICS_DELAY;
            next_dly = 3'h1;
            next_ovr = '0;
            next_spc = pick_pc;
          end
        end
        ICS_DELAY: begin
          if (ok0) begin
            sum0 = {1'b0, ctr0} + {18'h00000, nfetch};
            next_ctr0 = sum0[CW-1:0];
          end
          if (dly <= OVR_LAST) begin
            next_ovr = (4'(fetch_overcount) + 4'(nfetch) > 4'(OVR_MAX)) ? OVR_MAX :
                       fetch_overcount + nfetch;
          end
          next_dly = dly + 3'h1;
          if (dly == OPEN_DELAY - 3'h1) begin
            next_state = ICS_OPEN;
            next_age = '0;
          end
        end
        ICS_OPEN, ICS_CLOSE: begin
          // retire counts arrive with a variable lag, so the edges of the
          // window may gain or lose a few instructions
          if (ok0) begin
            sum0 = {1'b0, ctr0} + {17'h00000, inc_zero(sl1, RETIRE_CNT_I)};
            next_ctr0 = sum0[CW-1:0];
          end
          if (age != HOLD_SKIP) begin
            next_age = age + 2'h1;
          end
          if (state == ICS_OPEN && end_ev) begin
            next_state = ICS_CLOSE;
            next_ccnt = 2'h1;
            next_stat = SMP_STATUS_I;
          end
          if (state == ICS_CLOSE) begin
            next_ccnt = ccnt + 2'h1;
            if (ccnt == CLOSE_DELAY) begin
              next_state = ICS_DONE;
              if (IRQ_ENABLE_I[0]) begin
                next_pend[0] = 1'b1;
              end
            end
          end
        end
        ICS_DONE: begin
          next_state = ICS_DONE;
        end
        default: next_state = ICS_IDLE;
      endcase
      // the hold count skips the first two window cycles, so its final
      // value never passes the window length less two
      if (ok1) begin
        sum1 = {1'b0, ctr1} + 21'(inc_one(sl1,
          win && age == HOLD_SKIP,
          win && miss_sh[MISS_LEAD-1],
          win_d1 && REPLAY_TRAP_I,
          SMP_EV_I.retire_hold));
        // only the replay input runs on the window delayed by one cycle
        next_ctr1 = ((sl1 == SEL_CYC_REPLAY) ? win_d1 : win) ?
                    sum1[CW-1:0] : ctr1;
      end
    end
    if ((sum0[CW] && !sl0) || (sum1[CW] && (win || win_d1 || !sl0))) begin
      // an overflow raises only the pending bit whose enable is set
      next_pend = next_pend | (IRQ_ENABLE_I & {sum1[CW], sum0[CW]});
    end
    if (wr_ctrl) begin
      // a write rearms sampling; counter one is left as written, software
      // must supply zero itself
      next_sl0 = IPR_WDATA_I[SL0_BIT];
      next_sl1 = IPR_WDATA_I[SL1_LO +: 2];
      next_ctr0 = IPR_WDATA_I[CTR0_LO +: CW] + CTR_WRITE_BIAS;
      next_ctr1 = IPR_WDATA_I[CTR1_LO +: CW];
      next_state = ICS_IDLE;
      next_ovr = '0;
      // a pending bit set in the same cycle survives the clear
      next_pend = next_pend & ~(pend & ~(next_pend ^ pend));
      next_pend = next_pend & ~pend;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state <= ICS_IDLE;
      ctr0 <= '0;
      ctr1 <= '0;
      sl0 <= 1'b0;
      sl1 <= SEL_RET_CYC;
      dly <= '0;
      ccnt <= '0;
      age <= '0;
      fetch_overcount <= '0;
      spc <= '0;
      stat <= '0;
      pend <= '0;
      win_d1 <= 1'b0;
      miss_sh <= '0;
    end else if (CE_I) begin
      state <= next_state;
      ctr0 <= next_ctr0;
      ctr1 <= next_ctr1;
      sl0 <= next_sl0;
      sl1 <= next_sl1;
      dly <= next_dly;
      ccnt <= next_ccnt;
      age <= next_age;
      fetch_overcount <= next_ovr;
      spc <= next_spc;
      stat <= next_stat;
      pend <= next_pend;
      win_d1 <= next_win_d1;
      miss_sh <= next_miss_sh;
    end
  end

  always_comb begin
    IPR_RDATA_O = '0;
    case (IPR_SEL_I)
      ICS_SEL_PC: IPR_RDATA_O = spc;
      ICS_SEL_STAT: begin
        IPR_RDATA_O[FILL_BIT] = stat.new_fill_stream_flag;
        IPR_RDATA_O[TRAP_BIT] = stat.non_shadowed_trap_flag;
        IPR_RDATA_O[WRONG_BIT] = stat.wrong_branch_guess_flag;
        IPR_RDATA_O[KIND_LO +: KIND_W] = stat.trap_kind;
        IPR_RDATA_O[LSO_BIT] = stat.load_store_order_replay;
        IPR_RDATA_O[OVR_LO +: OVR_W] = fetch_overcount;
      end
      ICS_SEL_CTRL: begin
        IPR_RDATA_O[SL1_LO +: 2] = sl1;
        IPR_RDATA_O[SL0_BIT] = sl0;
        IPR_RDATA_O[CTR1_LO +: CW] = ctr1;
        IPR_RDATA_O[RET_OK_BIT] = stat.retired_ok_flag;
        IPR_RDATA_O[BR_DIR_BIT] = stat.branch_direction;
        IPR_RDATA_O[STALL_BIT] = stat.fetch_map_stall;
        IPR_RDATA_O[KILL_BIT] = stat.killed_by_map_stage;
        IPR_RDATA_O[CTR0_LO +: CW] = ctr0;
      end
      default: IPR_RDATA_O = '0;
    endcase
  end

  assign SMP_PICK_O = ovf_hit && CE_I && !wr_ctrl;
  assign SMP_SLOT_O = hit_slot;
  assign WINDOW_O = win;
  assign IRQ_PENDING_O = pend;

  sequence s_pick;
    state == ICS_IDLE && SMP_PICK_O;
  endsequence
  sequence s_end;
    state == ICS_OPEN && end_ev && !wr_ctrl;
  endsequence

  chk_write_bias: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CE_I)
    wr_ctrl |=> ctr0 == $past(IPR_WDATA_I[CTR0_LO +: CW]) + CTR_WRITE_BIAS)
    else $error("written counter zero lacks bias");
  chk_window_open: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CE_I)
    s_pick ##1 (!wr_ctrl)[*4] |=> state == ICS_OPEN)
    else $error("window not opened at fifth cycle");
  chk_close_start: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CE_I)
    s_end |=> state == ICS_CLOSE ##1 (state == ICS_CLOSE || $past(wr_ctrl)))
    else $error("window close not started");
  chk_close_done: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CE_I)
    s_end ##1 (!wr_ctrl)[*2] |=> state == ICS_DONE && !win)
    else $error("window not closed two cycles after end");
  chk_done_frozen: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CE_I)
    state == ICS_DONE && !wr_ctrl |=> $stable(ctr0))
    else $error("counter zero moved after close");
  chk_overcount_hold: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CE_I)
    state == ICS_DELAY && dly > OVR_LAST && !wr_ctrl |=> $stable(fetch_overcount))
    else $error("overcount changed outside its two cycles");
  chk_fetch_count: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CE_I)
    sl0 && state == ICS_IDLE && !wr_ctrl |=>
      ctr0 == $past(ctr0) + ($past(ok0) ? 20'($past(nfetch)) : 20'h00000))
    else $error("fetch count wrong");
  chk_pc_capture: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CE_I)
    s_pick |=> spc == $past(pick_pc))
    else $error("sampled pc not captured");
  chk_irq_gate: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CE_I)
    $rose(pend[0]) |-> $past(IRQ_ENABLE_I[0]))
    else $error("pending set while disabled");
endmodule

// ===== verif/ics_counters_tb.sv
// self-checking bench for the instruction sampling counters
`timescale 1ns/10ps
module ics_counters_tb;
  import ics_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wr = 1'b0;
  ics_ipr_e sel = ICS_SEL_NONE;
  logic [PCW-1:0] wdata = '0;
  logic [PCW-1:0] rdata;
  ics_en_s en = '0;
  logic [1:0] irq_en = 2'h0;
  logic [SLOTS-1:0] fv = '0;
  logic [SLOTS-1:0][PCW-1:0] fpc = '0;
  logic [3:0] ret_cnt = 4'h0;
  logic miss = 1'b0;
  logic replay = 1'b0;
  ics_ev_s ev = '0;
  ics_status_s st = '0;
  logic pick;
  logic [1:0] slot;
  logic win;
  logic [1:0] pend;
  int error_cnt = 0;
  int checks = 0;

  ics_counters ics_counters_inst (
    .CORE_CLK_I(clk),
    .SYS_RST_I(rst),
    .CE_I(ce),
    .IPR_WR_I(wr),
    .IPR_SEL_I(sel),
    .IPR_WDATA_I(wdata),
    .IPR_RDATA_O(rdata),
    .EN_I(en),
    .IRQ_ENABLE_I(irq_en),
    .FETCH_VALID_I(fv),
    .FETCH_PC_I(fpc),
    .RETIRE_CNT_I(ret_cnt),
    .CACHE_MISS_I(miss),
    .REPLAY_TRAP_I(replay),
    .SMP_EV_I(ev),
    .SMP_STATUS_I(st),
    .SMP_PICK_O(pick),
    .SMP_SLOT_O(slot),
    .WINDOW_O(win),
    .IRQ_PENDING_O(pend)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic cmp64(input string what, input logic [PCW-1:0] exp,
                       input logic [PCW-1:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmpb(input string what, input logic [1:0] exp,
                      input logic [1:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // one-cycle strobe; returns at the negedge of the following cycle
  task automatic wr_reg(input ics_ipr_e s, input logic [PCW-1:0] d);
    @(negedge clk);
    wr = 1'b1;
    sel = s;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input ics_ipr_e s, output logic [PCW-1:0] d);
    sel = s;
    #1;
    d = rdata;
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic reset_test();
    logic [PCW-1:0] d;
    #1;
    cmpb("window after reset", 2'h0, {1'b0, win});
    cmpb("pending after reset", 2'h0, pend);
    rd_reg(ICS_SEL_PC, d);
    cmp64("pc reset", '0, d);
    rd_reg(ICS_SEL_STAT, d);
    cmp64("stat reset", '0, d);
    rd_reg(ICS_SEL_CTRL, d);
    cmp64("ctrl reset", '0, d);
  endtask

  task automatic gating_test();
    logic [PCW-1:0] d;
    d = '0;
    d[SL0_BIT] = 1'b1;
    d[CTR0_LO +: CW] = 20'h00010;
    en = 4'b1100;
    wr_reg(ICS_SEL_CTRL, d);
    // squashed no-ops and move halves are plain valid slots here
    fv = 4'hF;
    @(negedge clk);
    @(negedge clk);
    fv = 4'h0;
    rd_reg(ICS_SEL_CTRL, d);
    cmp64("ctr0 gated", 64'(20'h00014), 64'(d[CTR0_LO +: CW]));
    en = 4'b1101;
    fv = 4'h5;
    @(negedge clk);
    en = 4'b0110;
    fv = 4'hF;
    @(negedge clk);
    fv = 4'h0;
    rd_reg(ICS_SEL_CTRL, d);
    cmp64("ctr0 enabled", 64'(20'h00016), 64'(d[CTR0_LO +: CW]));
    // a low clock enable must freeze the count despite valid fetches
    en = 4'b1101;
    ce = 1'b0;
    fv = 4'hF;
    @(negedge clk);
    fv = 4'h0;
    ce = 1'b1;
    rd_reg(ICS_SEL_CTRL, d);
    cmp64("ctr0 ce low", 64'(20'h00016), 64'(d[CTR0_LO +: CW]));
    wr_reg(ICS_SEL_STAT, '1);
    rd_reg(ICS_SEL_STAT, d);
    cmp64("stat read only", '0, d);
  endtask

  task automatic run_sample(input logic [1:0] mode_sel, input int kind,
                            input logic ien);
    logic [PCW-1:0] d;
    logic [PCW-1:0] c0v;
    logic [19:0] exp_c1;
    d = '0;
    d[SL0_BIT] = 1'b1;
    d[SL1_LO +: 2] = mode_sel;
    // plus the write bias this sits three fetches short of overflow
    d[CTR0_LO +: CW] = 20'hFFFF9;
    en = 4'hF;
    irq_en = {1'b0, ien};
    st = 12'b1011_0101_1010;
    wr_reg(ICS_SEL_CTRL, d);
    for (int k = 0; k < 12; k++) begin
      if (k > 0) begin
        @(negedge clk);
      end
      fv = (k == 0) ? 4'hF : (k == 1) ? 4'h3 : (k == 2) ? 4'h1 : 4'h0;
      fpc[2] = 64'h0000_1234_5678_9AB0 + k;
      miss = (mode_sel == SEL_RET_MISS) && (k == 1 || k == 2);
      replay = (mode_sel == SEL_CYC_REPLAY) && (k == 5 || k == 6);
      ev.retire_hold = (mode_sel == SEL_CYC_HOLD) && k >= 5 && k <= 10;
      ev.retire = (kind == 0) && (k == 8);
      ev.trap = (kind == 1) && (k == 8);
      ev.abort = (kind == 2) && (k == 8);
      ev.squash_end = (kind == 3) && (k == 8);
      #1;
      cmpb("pick", {1'b0, k == 0}, {1'b0, pick});
      if (k == 0) begin
        cmpb("slot", 2'h2, slot);
        cmpb("pending cleared", 2'h0, pend);
      end
      cmpb("window", {1'b0, k >= 5 && k <= 10}, {1'b0, win});
      if (k == 11) begin
        cmpb("pending", {1'b0, ien}, pend);
      end
    end
    ev = '0;
    miss = 1'b0;
    replay = 1'b0;
    rd_reg(ICS_SEL_PC, d);
    cmp64("sampled pc", 64'h0000_1234_5678_9AB0, d);
    // flags fill, wrong guess, kind A, order replay; overcount 2+1
    rd_reg(ICS_SEL_STAT, d);
    cmp64("status", 64'h3D5, d);
    case (mode_sel)
      SEL_RET_CYC: exp_c1 = 20'h6;
      SEL_CYC_HOLD: exp_c1 = 20'h4;
      default: exp_c1 = 20'h1;
    endcase
    rd_reg(ICS_SEL_CTRL, c0v);
    cmp64("ctrl", {34'h0, 4'h5, exp_c1, 2'h1, mode_sel, 2'h0},
          {34'h0, c0v[29:0]});
    // counting must stay halted until the next control write
    fv = 4'hF;
    ret_cnt = 4'h3;
    @(negedge clk);
    @(negedge clk);
    fv = 4'h0;
    ret_cnt = 4'h0;
    rd_reg(ICS_SEL_CTRL, d);
    cmp64("ctr0 frozen", 64'(c0v[CTR0_LO +: CW]),
          64'(d[CTR0_LO +: CW]));
    cmpb("window stays shut", 2'h0, {1'b0, win});
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    $display("mismatch run length expected done seen timeout");
    results();
  end

  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    reset_test();
    gating_test();
    // each select code paired with a different way of ending
    for (int i = 0; i < 4; i++) begin
      run_sample(i[1:0], i, i[0]);
    end
    results();
  end
endmodule
